// *** tmr8_pkg.sv ***
package tmr8_pkg;

    // ------------------------------------------------------------
    // register map and field layout
    // ------------------------------------------------------------
    localparam int          DATA_W          = 8;
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  TIMER_COUNT_OFS = 8'h01;
    localparam logic [7:0]  OPTIONS_OFS     = 8'h02;
    localparam logic [7:0]  WDT_CLEAR_OFS   = 8'h04;
    localparam logic [7:0]  OPTIONS_RST     = 8'hFF;
    localparam logic [7:0]  COUNT_RST       = 8'h00;
    localparam logic [7:0]  READ_ZERO       = 8'h00;
    localparam int          CS_BIT          = 5;
    localparam int          SE_BIT          = 4;
    localparam int          PSA_BIT         = 3;
    localparam int          PS_LSB          = 0;
    localparam int          PS_W            = 3;
    localparam int          PRESC_W         = 8;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS   = 50;
    localparam int          TOSC_NS         = 50;
    localparam int          TOSC_CLKS       = (TOSC_NS / CLK_PERIOD_NS < 1) ? 1 :
                                              TOSC_NS / CLK_PERIOD_NS;
    localparam int          PHASES          = 4;
    localparam int          INHIBIT_INSTR   = 2;
    localparam logic [1:0]  INHIBIT_LOAD    = 2'(INHIBIT_INSTR);

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic             wake_disable;
        logic             pullup_disable;
        logic             clock_source_select;
        logic             source_edge_select;
        logic             prescaler_assign;
        logic [PS_W-1:0]  prescale_rate;
    } tmr8_opt_t;

    typedef enum logic [3:0] {
        PH_Q1 = 4'h1,
        PH_Q2 = 4'h2,
        PH_Q3 = 4'h4,
        PH_Q4 = 4'h8
    } tmr8_phase_t;

    // low n bits set: group size of a 2^n ratio
    function automatic logic [PRESC_W-1:0] rate_mask(input logic [PS_W-1:0] n);
        logic [PRESC_W:0] one;
        one = {{PRESC_W{1'b0}}, 1'b1} << n;
        rate_mask = PRESC_W'(one - 1'b1);
    endfunction

endpackage

// *** tmr8_phase.sv ***
`timescale 1ns/1ns
module tmr8_phase
    import tmr8_pkg::*;
#(
    parameter int TOSC_DIV = TOSC_CLKS
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // phase strobes
    output logic      q2_q,
    output logic      q4_q
);

    logic [7:0]  div_q;
    logic        adv;
    tmr8_phase_t ph_q;

    assign adv = (div_q == 8'(TOSC_DIV - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 8'h00;
        end else begin
            div_q <= adv ? 8'h00 : div_q + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_q <= PH_Q1;
            q2_q <= 1'b0;
            q4_q <= 1'b0;
        end else begin
            q2_q <= adv && (ph_q == PH_Q1);
            q4_q <= adv && (ph_q == PH_Q3);
            if (adv) begin
                unique case (ph_q)
                    PH_Q1: ph_q <= PH_Q2;
                    PH_Q2: ph_q <= PH_Q3;
                    PH_Q3: ph_q <= PH_Q4;
                    PH_Q4: ph_q <= PH_Q1;
                    default: ph_q <= PH_Q1;
                endcase
            end
        end
    end

endmodule

// *** tmr8_presc.sv ***
`timescale 1ns/1ns
module tmr8_presc
    import tmr8_pkg::*;
#(
    parameter int W = PRESC_W
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // control
    input  wire logic         clr,
    input  wire logic         inc,
    // hidden count
    output logic [W-1:0]      count_q
);

    // clear beats a coincident count so a write never leaves a stale residue
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (clr) begin
            count_q <= '0;
        end else if (inc) begin
            count_q <= count_q + W'(1);
        end
    end

endmodule

// *** tmr8_top.sv ***
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
// Contract
// (R1) Source select 0, no prescaler: count advances every instruction cycle.
// (R2) After a count write, two instruction cycles pass without increment.
// (R3) Source select 1: count edges of the external input.
// (R4) Edge select 0 counts rising edges, 1 counts falling edges.
// (R5) Assign bit 0 gives prescaler to timer, 1 to watchdog, never both.
// (R6) Timer prescale ratios run 1:2 to 1:256 in powers of two.
// (R7) Rate field n divides by 2^(n+1).
// (R8) One 8-bit counter is timer prescaler or watchdog postscaler.
// (R9) Prescaler count is not readable or writable by software.
// (R10) Count writes clear the prescaler while it serves the timer.
// (R11) Watchdog clear resets prescaler while it serves the watchdog.
// (R12) Reset leaves the prescaler at zero.
// (R13) Prescaler output or raw input is sampled on second and fourth phases.
// (R14) Source holds input high and low two oscillator periods each.
// (R15) With prescaler, source period at least four periods over ratio.
// (R16) Count updates three to seven oscillator periods after input edge; the code takes up to ten, eleven with prescaler.
// (R17) Source select 1 forces the external pin to act as input.
// (R18) Count wraps from FF to 00 and keeps counting.
// (R19) Reset loads all ones into the options register.
module tmr8_top
    import tmr8_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata_q,
    // external count pin
    input  wire logic              external_count_input,
    input  wire logic              ext_dir_tris,
    output logic                   ext_pin_oe_q,
    // watchdog unit
    input  wire logic              wdt_tick,
    output logic                   wdt_clear_q,
    output logic                   wdt_post_q,
    // option bits for the port block
    output logic      [1:0]        port_opt_q
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_s1_q;
    logic rst_s2_q;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    assign rst_sync_n = rst_s2_q;

    // ------------------------------------------------------------
    // instruction phases
    // ------------------------------------------------------------
    logic q2_pulse;
    logic q4_pulse;

    tmr8_phase #(
        .TOSC_DIV (TOSC_CLKS)
    ) u_phase (
        .clk   (clk),
        .rst_n (rst_sync_n),
        .q2_q  (q2_pulse),
        .q4_q  (q4_pulse)
    );

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    tmr8_opt_t opt_q;
    logic      wr_count;
    logic      wr_opt;
    logic      wr_wdclr;
    logic      rd_count;

    assign wr_count = reg_wr && (reg_addr == TIMER_COUNT_OFS);
    assign wr_opt   = reg_wr && (reg_addr == OPTIONS_OFS);
    assign wr_wdclr = reg_wr && (reg_addr == WDT_CLEAR_OFS);
    assign rd_count = reg_rd && (reg_addr == TIMER_COUNT_OFS);

    // (R19) options reset to ones
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            opt_q <= tmr8_opt_t'(OPTIONS_RST);
        end else if (wr_opt) begin
            opt_q <= tmr8_opt_t'(reg_wdata);
        end
    end

    // ------------------------------------------------------------
    // external input synchroniser
    // ------------------------------------------------------------
    logic ext_s1_q;
    logic ext_s2_q;
    logic ext_s3_q;
    logic ext_lvl_q;
    logic src_lvl;
    logic src_prev_q;
    logic src_edge;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else begin
            ext_s1_q <= external_count_input;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    // level moves only once the last two stages agree
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ext_lvl_q <= 1'b0;
        end else if (ext_s2_q == ext_s3_q) begin
            ext_lvl_q <= ext_s3_q;
        end
    end

    // (R4) invert so the chosen edge always rises
    assign src_lvl  = ext_lvl_q ^ opt_q.source_edge_select;
    assign src_edge = src_lvl && !src_prev_q;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            src_prev_q <= OPTIONS_RST[SE_BIT];
        end else begin
            src_prev_q <= src_lvl;
        end
    end

    // ------------------------------------------------------------
    // shared prescaler
    // ------------------------------------------------------------
    logic [PRESC_W-1:0] presc_cnt;
    logic               presc_inc;
    logic               presc_clr;
    logic               to_timer;

    // (R5) one owner at a time
    assign to_timer = !opt_q.prescaler_assign;

    // (R3) external edges or instruction cycles feed it for the timer, watchdog ticks otherwise
    always_comb begin
        if (to_timer) begin
            presc_inc = opt_q.clock_source_select ? src_edge : q4_pulse;
        end else begin
            presc_inc = wdt_tick;
        end
    end

    // (R10) count write clears
    // (R11) watchdog clear clears
    assign presc_clr = (wr_count && to_timer) || (wr_wdclr && !to_timer);

    // (R8) single counter, (R9) never on the bus, (R12) zero at reset
    tmr8_presc #(
        .W (PRESC_W)
    ) u_presc (
        .clk     (clk),
        .rst_n   (rst_sync_n),
        .clr     (presc_clr),
        .inc     (presc_inc),
        .count_q (presc_cnt)
    );

    // ------------------------------------------------------------
    // phase sampling
    // ------------------------------------------------------------
    logic timer_lvl;
    logic samp2_q;
    logic samp4_q;
    logic samp_rise;

    // (R6) (R7) tap n toggles every 2^n events: ratio 2^(n+1)
    always_comb begin
        if (to_timer) begin
            timer_lvl = presc_cnt[opt_q.prescale_rate];
        end else begin
            timer_lvl = opt_q.clock_source_select ? src_lvl : 1'b0;
        end
    end

    // (R13) sample on second and fourth phases; reset at idle level, no false count
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            samp2_q <= OPTIONS_RST[SE_BIT];
            samp4_q <= OPTIONS_RST[SE_BIT];
        end else begin
            if (q2_pulse) begin
                samp2_q <= timer_lvl;
            end
            if (q4_pulse) begin
                samp4_q <= samp2_q;
            end
        end
    end

    // (R16) increment lands at the fourth phase after the edge is seen
    assign samp_rise = q4_pulse && samp2_q && !samp4_q;

    // ------------------------------------------------------------
    // write inhibit
    // ------------------------------------------------------------
    logic [1:0] inh_q;
    logic       step;
    logic       step_ok;

    // (R1) plain instruction-cycle step
    always_comb begin
        if (!opt_q.clock_source_select && !to_timer) begin
            step = q4_pulse;
        end else begin
            step = samp_rise;
        end
    end

    // (R2) two instruction cycles without increment
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            inh_q <= 2'h0;
        end else if (wr_count) begin
            inh_q <= INHIBIT_LOAD;
        end else if (q4_pulse && (inh_q != 2'h0)) begin
            inh_q <= inh_q - 2'h1;
        end
    end

    assign step_ok = step && (inh_q == 2'h0) && !wr_count;

    // ------------------------------------------------------------
    // timer count
    // ------------------------------------------------------------
    logic [DATA_W-1:0] count_q;

    // (R18) free-running wrap past FF
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            count_q <= COUNT_RST;
        end else if (wr_count) begin
            count_q <= reg_wdata;
        end else if (step_ok) begin
            count_q <= count_q + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // options and clear command are write-only and read back zero
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            reg_rdata_q <= READ_ZERO;
        end else if (rd_count) begin
            reg_rdata_q <= count_q;
        end else begin
            reg_rdata_q <= READ_ZERO;
        end
    end

    // ------------------------------------------------------------
    // watchdog side
    // ------------------------------------------------------------
    logic [PRESC_W-1:0] wd_mask;

    assign wd_mask = rate_mask(opt_q.prescale_rate);

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wdt_clear_q <= 1'b0;
        end else begin
            wdt_clear_q <= wr_wdclr;
        end
    end

    // postscaled tick: last tick of each 2^n group, or every tick if unassigned
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wdt_post_q <= 1'b0;
        end else if (to_timer) begin
            wdt_post_q <= wdt_tick;
        end else begin
            wdt_post_q <= wdt_tick && !presc_clr && ((presc_cnt & wd_mask) == wd_mask);
        end
    end

    // ------------------------------------------------------------
    // pin direction
    // ------------------------------------------------------------
    // (R17) counter mode overrides direction
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ext_pin_oe_q <= 1'b0;
        end else begin
            ext_pin_oe_q <= !(opt_q.clock_source_select || ext_dir_tris);
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            port_opt_q <= OPTIONS_RST[7:6];
        end else begin
            port_opt_q <= {opt_q.wake_disable, opt_q.pullup_disable};
        end
    end

endmodule

// *** tmr8_top_props.sv ***
`timescale 1ns/1ns
module tmr8_top_props
    import tmr8_pkg::*;
(
    // clock and reset
    input wire logic              clk,
    input wire logic              rst_n,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata_q,
    // pin and watchdog
    input wire logic              external_count_input,
    input wire logic              ext_dir_tris,
    input wire logic              ext_pin_oe_q,
    input wire logic              wdt_tick,
    input wire logic              wdt_clear_q,
    input wire logic              wdt_post_q,
    input wire logic [1:0]        port_opt_q
);
    // ------------------------------------------------------------
    // options shadow
    // ------------------------------------------------------------
    // options cannot be read back, so the checker keeps its own copy
    logic [DATA_W-1:0] opt_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opt_q <= OPTIONS_RST;
        end else if (reg_wr && reg_addr == OPTIONS_OFS) begin
            opt_q <= reg_wdata;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    rd_zero_a: assert property (
        reg_rd && reg_addr != TIMER_COUNT_OFS |=> reg_rdata_q == READ_ZERO)
        else $error("read of a non-count address gave data");
    wr_hold_a: assert property (
        reg_wr && reg_addr == TIMER_COUNT_OFS ##1 !reg_wr
        ##1 reg_rd && reg_addr == TIMER_COUNT_OFS |=> reg_rdata_q == $past(reg_wdata, 3))
        else $error("count moved right after a write");
    clr_pulse_a: assert property (
        reg_wr && reg_addr == WDT_CLEAR_OFS |=> wdt_clear_q
        ##1 wdt_clear_q == ($past(reg_wr) && $past(reg_addr) == WDT_CLEAR_OFS))
        else $error("watchdog clear pulse missing or too long");
    clr_only_a: assert property (
        wdt_clear_q |-> $past(reg_wr) && $past(reg_addr) == WDT_CLEAR_OFS)
        else $error("watchdog clear without a clear command");
    oe_input_a: assert property (
        opt_q[CS_BIT] && $past(opt_q[CS_BIT]) |-> !ext_pin_oe_q)
        else $error("pin driven while counting external edges");
    post_mirror_a: assert property (
        !opt_q[PSA_BIT] && !$past(opt_q[PSA_BIT]) |-> wdt_post_q == $past(wdt_tick))
        else $error("watchdog tick not passed straight through");
    post_tick_a: assert property (wdt_post_q |-> $past(wdt_tick))
        else $error("postscaled tick without a base tick");
    port_bits_a: assert property (
        $stable(opt_q) |-> port_opt_q == opt_q[7:6])
        else $error("port option bits differ from options");
endmodule

// *** tmr8_src.sv ***
`timescale 1ns/1ns
module tmr8_src (
    // clock
    input wire logic clk,
    // count pin
    output logic     pin
);
    initial pin = 1'b0;
    task automatic pulses(input int n, input int hi, input int lo);
        for (int i = 0; i < n; i++) begin
            @(posedge clk) pin <= 1'b1;
            repeat (hi) @(posedge clk);
            pin <= 1'b0;
            repeat (lo) @(posedge clk);
        end
    endtask
    task automatic level(input logic v);
        @(posedge clk) pin <= v;
    endtask
endmodule

// *** test_timer8_with_shared_prescaler.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module test_timer8_with_shared_prescaler
    import tmr8_pkg::*;
;
    logic              clk;
    logic              rst_n;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [DATA_W-1:0] reg_rdata_q;
    logic              ext_pin;
    logic              ext_dir_tris;
    logic              ext_pin_oe_q;
    logic              wdt_tick;
    logic              wdt_clear_q;
    logic              wdt_post_q;
    logic [1:0]        port_opt_q;
    int                mismatches;
    int                total_checks;
    int                posts;
    logic [DATA_W-1:0] v1;
    logic [DATA_W-1:0] v2;

    tmr8_top u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .external_count_input(ext_pin), .ext_dir_tris(ext_dir_tris),
        .ext_pin_oe_q(ext_pin_oe_q), .wdt_tick(wdt_tick), .wdt_clear_q(wdt_clear_q),
        .wdt_post_q(wdt_post_q), .port_opt_q(port_opt_q));
    tmr8_src u_src (.clk(clk), .pin(ext_pin));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // counted on the falling edge, away from the bench's own updates
    always @(negedge clk) if (wdt_post_q === 1'b1) posts++;

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata_q;
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            wdt_tick <= 1'b1;
            @(posedge clk);
            wdt_tick <= 1'b0;
        end
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        $display("unexpected at %0t: run too long", $time);
        mismatches++;
        final_report();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, reg_addr, reg_wdata, reg_wr, reg_rd, ext_dir_tris, wdt_tick} = '0;
        {mismatches, total_checks, posts} = '0;
        do_reset();
        rd(TIMER_COUNT_OFS, v1);
        `CHK(v1, COUNT_RST)
        `CHK(port_opt_q, 2'b11)
        `CHK(ext_pin_oe_q, 1'b0)
        rd(OPTIONS_OFS, v1);
        `CHK(v1, READ_ZERO)
        rd(8'h33, v1);
        `CHK(v1, READ_ZERO)
        $display("test reset done");
        wr(OPTIONS_OFS, 8'h08);
        wr(TIMER_COUNT_OFS, 8'hFE);
        rd(TIMER_COUNT_OFS, v1);
        `CHK(v1, 8'hFE)
        `CHK(ext_pin_oe_q, 1'b1)
        @(posedge clk) ext_dir_tris <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(ext_pin_oe_q, 1'b0)
        ext_dir_tris <= 1'b0;
        repeat (38) @(posedge clk);
        rd(TIMER_COUNT_OFS, v1);
        repeat (38) @(posedge clk);
        rd(TIMER_COUNT_OFS, v2);
        `CHK(v2, 8'(v1 + 8'h0A))
        `CHK(v1 < 8'h10, 1'b1)
        $display("test internal done");
        for (int n = 0; n < 8; n++) begin
            wr(OPTIONS_OFS, 8'(n));
            wr(TIMER_COUNT_OFS, 8'h00);
            repeat (16 << n) @(posedge clk);
            rd(TIMER_COUNT_OFS, v1);
            repeat ((32 << n) - 2) @(posedge clk);
            rd(TIMER_COUNT_OFS, v2);
            `CHK(v2, 8'(v1 + 8'h04))
        end
        wr(TIMER_COUNT_OFS, 8'h00);
        repeat (3) begin
            repeat (400) @(posedge clk);
            rd(TIMER_COUNT_OFS, v1);
            `CHK(v1, 8'h00)
            wr(TIMER_COUNT_OFS, 8'h00);
        end
        $display("test prescaler done");
        for (int se = 0; se < 2; se++) begin
            wr(OPTIONS_OFS, 8'h28 | 8'(se << 4));
            wr(TIMER_COUNT_OFS, 8'h00);
            repeat (8) @(posedge clk);
            u_src.level(1'b1);
            repeat (12) @(posedge clk);
            rd(TIMER_COUNT_OFS, v1);
            `CHK(v1, 8'(1 - se))
            u_src.level(1'b0);
            repeat (12) @(posedge clk);
            rd(TIMER_COUNT_OFS, v1);
            `CHK(v1, 8'h01)
        end
        for (int p = 0; p < 2; p++) begin
            wr(OPTIONS_OFS, (p == 1) ? 8'h20 : 8'h28);
            wr(TIMER_COUNT_OFS, 8'h00);
            repeat (8) @(posedge clk);
            u_src.pulses(8, 4, 3);
            repeat (16) @(posedge clk);
            rd(TIMER_COUNT_OFS, v1);
            `CHK(v1, (p == 1) ? 8'h04 : 8'h08)
        end
        $display("test external done");
        wr(OPTIONS_OFS, 8'h0A);
        wr(WDT_CLEAR_OFS, 8'h00);
        posts = 0;
        tick(8);
        repeat (2) @(posedge clk);
        `CHK(posts, 2)
        posts = 0;
        tick(3);
        wr(WDT_CLEAR_OFS, 8'h00);
        tick(3);
        repeat (2) @(posedge clk);
        `CHK(posts, 0)
        wr(OPTIONS_OFS, 8'h02);
        posts = 0;
        tick(4);
        repeat (2) @(posedge clk);
        `CHK(posts, 4)
        $display("test watchdog done");
        do_reset();
        `CHK(port_opt_q, 2'b11)
        wr(OPTIONS_OFS, 8'h20);
        repeat (8) @(posedge clk);
        u_src.pulses(1, 4, 3);
        repeat (16) @(posedge clk);
        rd(TIMER_COUNT_OFS, v1);
        `CHK(v1, 8'h01)
        $display("test second reset done");
        final_report();
    end
endmodule

bind tmr8_top tmr8_top_props u_props (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .external_count_input(external_count_input), .ext_dir_tris(ext_dir_tris),
    .ext_pin_oe_q(ext_pin_oe_q), .wdt_tick(wdt_tick), .wdt_clear_q(wdt_clear_q),
    .wdt_post_q(wdt_post_q), .port_opt_q(port_opt_q));
